// ===== rtl/rsse_pkg.sv
// shared constants and types for the rotate/subtract/sleep execution block
package rsse_pkg;
	localparam int RSSE_DATA_W = 8;
	localparam int RSSE_FADDR_W = 7;
	localparam int RSSE_FILE_DEPTH = 128;
	localparam int RSSE_PRESCALE_W = 4;
	localparam int RSSE_WDT_W = 8;

	// register byte offsets
	localparam logic [7:0] RSSE_OFS_CMD = 8'h00;
	localparam logic [7:0] RSSE_OFS_ACC = 8'h04;
	localparam logic [7:0] RSSE_OFS_STATUS = 8'h08;
	localparam logic [7:0] RSSE_OFS_FPTR = 8'h0C;
	localparam logic [7:0] RSSE_OFS_FDATA = 8'h10;
	localparam logic [7:0] RSSE_OFS_WDT = 8'h14;

	// command word fields
	localparam int RSSE_CMD_OP_LSB = 0;
	localparam int RSSE_CMD_DEST_BIT = 3;
	localparam int RSSE_CMD_FADDR_LSB = 4;

	// status word fields
	localparam int RSSE_ST_CARRY = 0;
	localparam int RSSE_ST_DIGIT = 1;
	localparam int RSSE_ST_ZERO = 2;
	localparam int RSSE_ST_PD_N = 3;
	localparam int RSSE_ST_TO_N = 4;

	// reset values
	localparam logic [7:0] RSSE_ACC_RST = 8'h00;
	localparam logic RSSE_FLAG_RST = 1'b0;
	localparam logic RSSE_PD_N_RST = 1'b1;
	localparam logic RSSE_TO_N_RST = 1'b1;
	localparam logic [7:0] RSSE_WDT_CLEAR = 8'h00;
	localparam logic [3:0] RSSE_PRESCALE_CLEAR = 4'h0;

	typedef enum logic [2:0] {
		RSSE_OP_NOP = 3'h0,
		RSSE_OP_ROL = 3'h1,
		RSSE_OP_ROR = 3'h3,
		RSSE_OP_SUB = 3'h2,
		RSSE_OP_SUBB = 3'h6,
		RSSE_OP_SLEEP = 3'h7
	} rsse_op_type;
endpackage

// ===== rtl/rsse_exec.sv
// execution datapath for rotate, subtract and sleep with an apb register file
//
// Behaviour
// [RL1] rotate left: carry into bit0, bit7 out
// [RL2] destination 0 writes accumulator, file kept
// [RL3] rotate right: carry into bit7, bit0 out
// [RL4] destination 1 writes back to file
// [RL5] sleep clears watchdog counter and prescaler
// [RL6] sleep clears powerdown_n, sets timeout_n
// [RL7] subtract: file minus accumulator, 8-bit
// [RL8] subtract destination: 0 accumulator, 1 file
// [RL9] carry/digit carry mean accumulator <= file
// [RL10] zero flag when difference is zero
// [RL11] borrow variant also subtracts inverted carry
//
// The register offsets and the APB slave port are this design's own decisions.
module rsse_exec #(
	parameter int FILE_DEPTH = rsse_pkg::RSSE_FILE_DEPTH,
	parameter int PRESCALE_W = rsse_pkg::RSSE_PRESCALE_W
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// core status
	output logic sleep_pulse,
	output logic timeout_flag_n,
	output logic powerdown_flag_n
);
	import rsse_pkg::*;

	if (FILE_DEPTH != RSSE_FILE_DEPTH || PRESCALE_W != RSSE_PRESCALE_W)
	begin : param_check
		$error("rsse_exec: unsupported parameter values");
	end

	logic [7:0] file_mem [FILE_DEPTH];
	logic [7:0] acc_q, acc_d;
	logic carry_q, carry_d, digit_carry_q, digit_carry_d, zero_q, zero_d;
	logic pd_n_q, pd_n_d, to_n_q, to_n_d;
	logic [RSSE_FADDR_W-1:0] fptr_q, fptr_d;
	logic [RSSE_WDT_W-1:0] watchdog_counter_q, watchdog_counter_d;
	logic [PRESCALE_W-1:0] prescale_q, prescale_d;
	logic [31:0] prdata_q, prdata_d;
	logic pslverr_q, pslverr_d, sleep_q, sleep_d;
	logic ready_q, ready_d;

	logic access, wr, mapped, exec;
	rsse_op_type op;
	logic dest;
	logic [RSSE_FADDR_W-1:0] faddr, mem_addr;
	logic [7:0] f_val, result, mem_wdata;
	logic [8:0] diff9;
	logic [4:0] diff5;
	logic borrow, mem_we;

	assign access = psel && penable;
	assign wr = access && pwrite && ready_q;
	assign mapped = paddr == RSSE_OFS_CMD || paddr == RSSE_OFS_ACC || paddr == RSSE_OFS_STATUS
		|| paddr == RSSE_OFS_FPTR || paddr == RSSE_OFS_FDATA || paddr == RSSE_OFS_WDT;
	assign exec = wr && paddr == RSSE_OFS_CMD;
	assign op = rsse_op_type'(pwdata[RSSE_CMD_OP_LSB +: 3]);
	assign dest = pwdata[RSSE_CMD_DEST_BIT];
	assign faddr = pwdata[RSSE_CMD_FADDR_LSB +: RSSE_FADDR_W];
	assign f_val = file_mem[faddr];
	// plain subtract has no borrow in; the borrow form takes inverted carry
	assign borrow = (op == RSSE_OP_SUBB) ? ~carry_q : 1'b0; // RL11
	assign diff9 = {1'b0, f_val} - {1'b0, acc_q} - {8'h00, borrow}; // RL7
	assign diff5 = {1'b0, f_val[3:0]} - {1'b0, acc_q[3:0]} - {4'h0, borrow};
	assign pready = ready_q;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;
	assign sleep_pulse = sleep_q;
	assign timeout_flag_n = to_n_q;
	assign powerdown_flag_n = pd_n_q;

	always_comb
	begin
		acc_d = acc_q;
		carry_d = carry_q;
		digit_carry_d = digit_carry_q;
		zero_d = zero_q;
		pd_n_d = pd_n_q;
		to_n_d = to_n_q;
		fptr_d = fptr_q;
		sleep_d = 1'b0;
		result = f_val;
		mem_we = 1'b0;
		mem_addr = fptr_q;
		mem_wdata = pwdata[7:0];
		// watchdog ticks once per prescaler wrap
		prescale_d = prescale_q + 1'b1;
		watchdog_counter_d = watchdog_counter_q + {{(RSSE_WDT_W-1){1'b0}}, &prescale_q};
		if (exec)
		begin
			unique case (op)
				RSSE_OP_ROL:
				begin
					result = {f_val[6:0], carry_q}; // RL1
					carry_d = f_val[7]; // RL1
				end
				RSSE_OP_ROR:
				begin
					result = {carry_q, f_val[7:1]}; // RL3
					carry_d = f_val[0]; // RL3
				end
				RSSE_OP_SUB, RSSE_OP_SUBB:
				begin
					result = diff9[7:0];
					carry_d = ~diff9[8]; // RL9
					digit_carry_d = ~diff5[4]; // RL9
					zero_d = diff9[7:0] == 8'h00; // RL10
				end
				RSSE_OP_SLEEP:
				begin
					watchdog_counter_d = RSSE_WDT_CLEAR; // RL5
					prescale_d = RSSE_PRESCALE_CLEAR; // RL5
					pd_n_d = 1'b0; // RL6
					to_n_d = 1'b1; // RL6
					sleep_d = 1'b1;
				end
				default:
				begin
				end
			endcase
			if (op == RSSE_OP_ROL || op == RSSE_OP_ROR || op == RSSE_OP_SUB || op == RSSE_OP_SUBB)
			begin
				if (dest) // RL4 RL8
				begin
					mem_we = 1'b1;
					mem_addr = faddr;
					mem_wdata = result;
				end
				else // RL2 RL8
					acc_d = result;
			end
		end
		else if (wr)
		begin
			if (paddr == RSSE_OFS_ACC)
				acc_d = pwdata[7:0];
			if (paddr == RSSE_OFS_STATUS)
			begin
				carry_d = pwdata[RSSE_ST_CARRY];
				digit_carry_d = pwdata[RSSE_ST_DIGIT];
				zero_d = pwdata[RSSE_ST_ZERO];
			end
			if (paddr == RSSE_OFS_FPTR)
				fptr_d = pwdata[RSSE_FADDR_W-1:0];
			if (paddr == RSSE_OFS_FDATA)
				mem_we = 1'b1;
		end
	end

	// one wait state: read data and error are loaded into flops on the same edge that raises pready
	always_comb
	begin
		prdata_d = 32'h0000_0000;
		pslverr_d = access && !mapped && !ready_q;
		ready_d = access && !ready_q;
		if (access && !pwrite && !ready_q)
		begin
			if (paddr == RSSE_OFS_ACC)
				prdata_d[7:0] = acc_q;
			if (paddr == RSSE_OFS_STATUS)
			begin
				prdata_d[RSSE_ST_CARRY] = carry_q;
				prdata_d[RSSE_ST_DIGIT] = digit_carry_q;
				prdata_d[RSSE_ST_ZERO] = zero_q;
				prdata_d[RSSE_ST_PD_N] = pd_n_q;
				prdata_d[RSSE_ST_TO_N] = to_n_q;
			end
			if (paddr == RSSE_OFS_FPTR)
				prdata_d[RSSE_FADDR_W-1:0] = fptr_q;
			if (paddr == RSSE_OFS_FDATA)
				prdata_d[7:0] = file_mem[fptr_q];
			if (paddr == RSSE_OFS_WDT)
				prdata_d[RSSE_WDT_W-1:0] = watchdog_counter_q;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			acc_q <= RSSE_ACC_RST;
			carry_q <= RSSE_FLAG_RST;
			digit_carry_q <= RSSE_FLAG_RST;
			zero_q <= RSSE_FLAG_RST;
			pd_n_q <= RSSE_PD_N_RST;
			to_n_q <= RSSE_TO_N_RST;
			fptr_q <= '0;
			watchdog_counter_q <= RSSE_WDT_CLEAR;
			prescale_q <= RSSE_PRESCALE_CLEAR;
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
			sleep_q <= 1'b0;
			ready_q <= 1'b0;
		end
		else
		begin
			acc_q <= acc_d;
			carry_q <= carry_d;
			digit_carry_q <= digit_carry_d;
			zero_q <= zero_d;
			pd_n_q <= pd_n_d;
			to_n_q <= to_n_d;
			fptr_q <= fptr_d;
			watchdog_counter_q <= watchdog_counter_d;
			prescale_q <= prescale_d;
			prdata_q <= prdata_d;
			pslverr_q <= pslverr_d;
			sleep_q <= sleep_d;
			ready_q <= ready_d;
		end
	end

	// file storage has no reset; software loads it before use
	always_ff @(posedge sys_clk)
	begin
		if (mem_we)
			file_mem[mem_addr] <= mem_wdata;
	end

	// helper state for the checks below
	logic [7:0] f_prev_q, acc_prev_q;
	logic c_prev_q, dest_prev_q, dc_prev_q;
	logic [RSSE_FADDR_W-1:0] a_prev_q;
	rsse_op_type op_prev_q;
	logic exec_prev_q;
	// no reset needed: checks are off in reset and exec is low there
	always_ff @(posedge sys_clk)
	begin
		f_prev_q <= f_val;
		acc_prev_q <= acc_q;
		c_prev_q <= carry_q;
		dc_prev_q <= digit_carry_q;
		dest_prev_q <= dest;
		a_prev_q <= faddr;
		op_prev_q <= op;
		exec_prev_q <= exec;
	end

	logic [7:0] dest_val;
	assign dest_val = dest_prev_q ? file_mem[a_prev_q] : acc_q;

	rotate_left_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL1
		exec_prev_q && op_prev_q == RSSE_OP_ROL |-> dest_val == {f_prev_q[6:0], c_prev_q}
		&& carry_q == f_prev_q[7] && digit_carry_q == dc_prev_q)
		else $error("rotate left result wrong");
	rotate_right_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL3
		exec_prev_q && op_prev_q == RSSE_OP_ROR |-> dest_val == {c_prev_q, f_prev_q[7:1]}
		&& carry_q == f_prev_q[0])
		else $error("rotate right result wrong");
	rot_to_acc_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL2
		exec_prev_q && !dest_prev_q && (op_prev_q == RSSE_OP_ROL || op_prev_q == RSSE_OP_ROR)
		|-> file_mem[a_prev_q] == f_prev_q)
		else $error("rotate to accumulator touched file");
	rot_to_file_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL4
		exec_prev_q && dest_prev_q && (op_prev_q == RSSE_OP_ROL || op_prev_q == RSSE_OP_ROR)
		|-> acc_q == acc_prev_q && dest_val == (op_prev_q == RSSE_OP_ROL
		? {f_prev_q[6:0], c_prev_q} : {c_prev_q, f_prev_q[7:1]}))
		else $error("rotate to file result wrong");
	sequence wdt_cleared_s;
		watchdog_counter_q == RSSE_WDT_CLEAR && prescale_q == RSSE_PRESCALE_CLEAR
		##1 watchdog_counter_q == RSSE_WDT_CLEAR;
	endsequence
	sleep_wdt_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL5
		exec && op == RSSE_OP_SLEEP |=> wdt_cleared_s)
		else $error("sleep did not clear watchdog");
	sleep_flags_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL6
		exec && op == RSSE_OP_SLEEP |=> !powerdown_flag_n && timeout_flag_n && sleep_pulse
		&& carry_q == $past(carry_q) && zero_q == $past(zero_q))
		else $error("sleep status bits wrong");
	sub_value_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL7
		exec_prev_q && op_prev_q == RSSE_OP_SUB |-> dest_val == f_prev_q - acc_prev_q)
		else $error("subtract difference wrong");
	sub_dest_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL8
		exec_prev_q && op_prev_q == RSSE_OP_SUB && dest_prev_q |-> acc_q == acc_prev_q)
		else $error("subtract to file touched accumulator");
	sub_carry_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL9
		exec_prev_q && op_prev_q == RSSE_OP_SUB |-> carry_q == (acc_prev_q <= f_prev_q)
		&& digit_carry_q == (acc_prev_q[3:0] <= f_prev_q[3:0]))
		else $error("subtract carry flags wrong");
	sub_zero_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL10
		exec_prev_q && (op_prev_q == RSSE_OP_SUB || op_prev_q == RSSE_OP_SUBB)
		|-> zero_q == (dest_val == 8'h00))
		else $error("subtract zero flag wrong");
	subb_value_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL11
		exec_prev_q && op_prev_q == RSSE_OP_SUBB
		|-> dest_val == f_prev_q - acc_prev_q - {7'h00, ~c_prev_q})
		else $error("borrow subtract difference wrong");
endmodule

// ===== sim/rsse_exec_tb.sv
// self-checking bench for the rotate/subtract/sleep execution block
module rsse_exec_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import rsse_pkg::*;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic sleep_pulse;
	logic timeout_flag_n;
	logic powerdown_flag_n;
	int fails = 0;
	int checks = 0;
	logic [31:0] seed = 32'hC29B835C;
	logic [7:0] mem [128];
	logic [7:0] acc;
	logic c, dc, z, pdn, ton, err;
	logic [31:0] rd, r;

	always #5 sys_clk = ~sys_clk;

	rsse_exec dut (
		.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sleep_pulse(sleep_pulse),
		.timeout_flag_n(timeout_flag_n), .powerdown_flag_n(powerdown_flag_n)
	);

	task wrap_up;
		if (fails == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task rnd;
		seed = lfsr(seed);
		r = seed;
	endtask

	// request held until pready is seen high at an edge; data taken at that edge
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			fails++;
			wrap_up();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, rd, exp);
	endtask

	function logic [31:0] st_exp();
		return {27'h0, ton, pdn, z, dc, c};
	endfunction

	// reference for one command; unknown codes and nop leave everything alone
	task model(input logic [2:0] op, input logic dest, input logic [6:0] fa);
		logic [7:0] f, res;
		logic b;
		f = mem[fa];
		res = f;
		b = (op == RSSE_OP_SUBB) ? ~c : 1'b0;
		case (op)
			RSSE_OP_ROL: {c, res} = {f, c};
			RSSE_OP_ROR: {res, c} = {c, f};
			RSSE_OP_SUB, RSSE_OP_SUBB:
			begin
				res = f - acc - {7'h0, b};
				c = {1'b0, f} >= ({1'b0, acc} + {8'h0, b});
				dc = {1'b0, f[3:0]} >= ({1'b0, acc[3:0]} + {4'h0, b});
				z = (res == 8'h00);
			end
			RSSE_OP_SLEEP: {pdn, ton} = 2'b01;
			default: ;
		endcase
		if (op inside {RSSE_OP_ROL, RSSE_OP_ROR, RSSE_OP_SUB, RSSE_OP_SUBB})
		begin
			if (dest)
				mem[fa] = res;
			else
				acc = res;
		end
	endtask

	initial
	begin
		repeat (8) @(posedge sys_clk);
		reset_n <= 1'b1;
		{acc, c, dc, z, pdn, ton} = {8'h00, 5'b00011};
		rchk("acc reset", RSSE_OFS_ACC, 32'h0);
		rchk("status reset", RSSE_OFS_STATUS, 32'h18);
		for (int i = 0; i < 128; i++)
		begin
			rnd();
			mem[i] = r[7:0];
			apb(1'b1, RSSE_OFS_FPTR, i);
			apb(1'b1, RSSE_OFS_FDATA, {24'h0, mem[i]});
		end
		// every code, both destinations; first passes hit equal operands and borrow in
		for (int k = 0; k < 120; k++)
		begin
			rnd();
			acc = (k < 16) ? mem[r[9:3]] : r[17:10];
			{z, dc, c} = (k < 8) ? 3'b000 : r[20:18];
			apb(1'b1, RSSE_OFS_ACC, {24'h0, acc});
			apb(1'b1, RSSE_OFS_STATUS, {29'h0, z, dc, c});
			apb(1'b1, RSSE_OFS_CMD, {21'h0, r[9:3], r[3 + 7], r[2:0]});
			model(r[2:0], r[10], r[9:3]);
			@(posedge sys_clk);
			chk("sleep pulse", sleep_pulse, r[2:0] == RSSE_OP_SLEEP);
			rchk("acc", RSSE_OFS_ACC, acc);
			rchk("status", RSSE_OFS_STATUS, st_exp());
			apb(1'b1, RSSE_OFS_FPTR, {25'h0, r[9:3]});
			rchk("file", RSSE_OFS_FDATA, mem[r[9:3]]);
			chk("mapped err", err, 1'b0);
		end
		// every prescaler phase: counter must still read zero 16 edges after sleep, then one
		for (int j = 0; j < 16; j++)
		begin
			repeat (j + 20) @(posedge sys_clk);
			apb(1'b1, RSSE_OFS_CMD, {29'h0, RSSE_OP_SLEEP});
			@(posedge sys_clk);
			chk("pd port", powerdown_flag_n, 1'b0);
			chk("to port", timeout_flag_n, 1'b1);
			chk("sleep pulse", sleep_pulse, 1'b1);
			// first read loads on the 16th edge after sleep, second after the first tick
			repeat (12) @(posedge sys_clk);
			rchk("wdt", RSSE_OFS_WDT, 32'h0);
			rchk("wdt tick", RSSE_OFS_WDT, 32'h1);
		end
		// powerdown_n and timeout_n bits are read-only, status write must not reach them
		apb(1'b1, RSSE_OFS_STATUS, 32'h08);
		rchk("status ro", RSSE_OFS_STATUS, 32'h10);
		apb(1'b0, 8'h18, 32'h0);
		chk("unmapped err", err, 1'b1);
		wrap_up();
	end
endmodule
